// ===== verification/dlss_lock_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dlss_lock_status_tb;
    import dlss_pkg::*;

    localparam int HALF = 16;

    logic mclk;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, locked;
    logic fbDividerOn, tdcEnable, feedbackSourceSelect, filterNormalSel;
    logic signed [31:0] phaseErr = 32'sh0;
    logic refValid = 1'b0;
    logic refSwitch = 1'b0;
    logic [1:0] refSelect = 2'h0;
    logic [30:0] tdcFine = 31'h0;
    logic [30:0] fineDigital;
    logic signed [15:0] sdmErr = 16'sh0;
    logic signed [23:0] corrOut;
    logic bigErr = 1'b0;
    logic er;
    logic [6:0] sm;
    logic [31:0] rd;
    logic [31:0] rnd = 32'h4a6b;
    logic [31:0] eRnd = 32'h4a6b;
    logic [7:0] rstAddr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rstVal [6] = '{32'h0, 32'h00ff0155, 32'h0, 32'h0, 32'h0,
        32'h0};
    int errors = 0;
    int samplesChecked = 0;

    dlss_lock_status #(.HALF_MS_CYCLES(HALF)) dlss_lock_status_inst (
        .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .phaseErr, .refValid,
        .refSwitch, .refSelect, .tdcFine, .sdmErr, .fbDividerOn,
        .tdcEnable, .feedbackSourceSelect, .filterNormalSel,
        .fineDigital, .corrOut, .locked
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [30:0] rev31(input logic [30:0] v);
        for (int i = 0; i < 31; i++) begin
            rev31[i] = v[30-i];
        end
    endfunction

    function automatic logic [31:0] sts(input logic [2:0] st, input logic lk);
        return {25'h0, st, 1'b0, refSelect, lk};
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, got);
        samplesChecked++;
        if (got !== ex) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] ex,
        input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask

    task automatic waitFor(input logic lk, output int n);
        n = 0;
        while ((lk ? locked : filterNormalSel) !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // phase error stays inside the threshold unless a burst is requested
    always @(posedge mclk) begin
        eRnd = lfsr(eRnd);
        sm = eRnd[6:0] % 7'h7f;
        if (bigErr) begin
            phaseErr <= eRnd[0] ? 32'sh80 : -32'sh80;
        end else begin
            phaseErr <= eRnd[7] ? -$signed({25'h0, sm}) : $signed({25'h0, sm});
        end
    end

    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        $display("mismatch watchdog expected finish seen hang");
        summarize;
    end

    initial begin
        logic [31:0] wd;
        logic [6:0] m;
        logic signed [15:0] sa, sb;
        logic signed [23:0] ex;
        int n;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rdChk(rstAddr[i], rstVal[i], "reset value");
        end
        wr(OFF_STATE_STS, 32'hff);
        rdChk(OFF_STATE_STS, 32'h0, "status after write");
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
        // correction settings apply at once, with the loop disabled or enabled
        for (int d = 0; d < 4; d++) begin
            rnd = lfsr(rnd);
            m = (d == 3) ? 7'h7f : rnd[6:0];
            wd = {16'h0, 1'b0, 5'h1f, rnd[8], d[1:0], m};
            wr(OFF_FB_CORR, wd);
            rdChk(OFF_FB_CORR, wd & 32'h83ff, "fb correction");
            sa = (d == 3) ? 16'sh8000 : rnd[15:0];
            sdmErr <= sa;
            tdcFine <= rnd[30:0];
            repeat (3) @(posedge mclk);
            rnd = lfsr(rnd);
            sb = rnd[31:16];
            sdmErr <= sb;
            repeat (2) @(posedge mclk);
            ex = ((d == 1) ? sa : sb) * $signed({1'b0, m});
            chk("corr first", {8'h0, ex}, {8'h0, corrOut});
            chk("fine digital", {1'b0, wd[9] ? rev31(tdcFine) : tdcFine},
                {1'b0, fineDigital});
            @(posedge mclk);
            ex = sb * $signed({1'b0, m});
            chk("corr second", {8'h0, ex}, {8'h0, corrOut});
        end
        for (int k = 0; k < 4; k++) begin
            wr(OFF_LOOP_CTRL, {28'h0, k[1], 2'h0, k[0]});
            wr(OFF_FB_CORR, {16'h0, k[1], 15'h0});
            repeat (2) @(posedge mclk);
            chk("divider on", {31'h0, k[0] & ~k[1]}, {31'h0, fbDividerOn});
            chk("source select", {31'h0, k[1]}, {31'h0, feedbackSourceSelect});
        end
        $display("test correction done");
        wr(OFF_FB_CORR, 32'h0);
        wr(OFF_LOOP_CTRL, 32'h0);
        wr(OFF_EVENTS, 32'hff);
        wr(OFF_LOCK_CFG, 32'h00020010);
        wr(OFF_EVENT_MASK, 32'h0d);
        rnd = lfsr(rnd);
        refSelect <= rnd[1:0];
        refValid <= 1'b1;
        wr(OFF_LOOP_CTRL, 32'h07);
        repeat (20) @(posedge mclk);
        chk("acquire filter", 32'h0, {31'h0, filterNormalSel});
        chk("tdc enable", 32'h1, {31'h0, tdcEnable});
        // one error sample at the threshold restarts qualification
        bigErr <= 1'b1;
        @(posedge mclk);
        bigErr <= 1'b0;
        @(posedge mclk);
        waitFor(1'b0, n);
        chk("acquire to normal", 32'h1, {31'h0, n >= 31 && n <= 38});
        chk("no early lock", 32'h0, {31'h0, locked});
        waitFor(1'b1, n);
        chk("normal to lock", 32'h1, {31'h0, n >= 30 && n <= 36});
        rdChk(OFF_STATE_STS, sts(3'h1, 1'b1), "locked status");
        rdChk(OFF_EVENTS, 32'h08, "state change flag");
        chk("irq set", 32'h1, {31'h0, irq});
        wr(OFF_EVENTS, 32'h08);
        rdChk(OFF_EVENTS, 32'h0, "flag cleared");
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("test lock done");
        bigErr <= 1'b1;
        repeat (2) @(posedge mclk);
        bigErr <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("lock dropped", 32'h0, {31'h0, locked});
        rdChk(OFF_EVENTS, 32'h01, "loss flag");
        refSwitch <= 1'b1;
        @(posedge mclk);
        refSwitch <= 1'b0;
        rdChk(OFF_STATE_STS, sts(3'h5, 1'b0), "hitless state");
        refValid <= 1'b0;
        repeat (2) @(posedge mclk);
        rdChk(OFF_STATE_STS, sts(3'h2, 1'b0), "holdover state");
        rdChk(OFF_EVENTS, 32'h0d, "all flags");
        wr(OFF_EVENT_MASK, 32'h0);
        @(posedge mclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFF_EVENT_MASK, 32'h04);
        wr(OFF_EVENTS, 32'h09);
        rdChk(OFF_EVENTS, 32'h04, "holdover flag kept");
        chk("irq holdover", 32'h1, {31'h0, irq});
        wr(OFF_EVENTS, 32'h04);
        @(posedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(OFF_LOOP_CTRL, 32'h0);
        rdChk(OFF_STATE_STS, sts(3'h0, 1'b0), "freerun state");
        wr(OFF_LOOP_CTRL, 32'h11);
        rdChk(OFF_STATE_STS, sts(3'h3, 1'b0), "write freq state");
        $display("test states done");
        summarize;
    end
endmodule // dlss_lock_status_tb
`default_nettype wire

// ===== verilog/dlss_lock_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dlss_lock_if;
    logic [15:0] lockTimer;
    logic errBelow;
    logic restart;
    logic halfDone;
    modport ctrl (output lockTimer, output errBelow, output restart,
        input halfDone);
    modport timer (input lockTimer, input errBelow, input restart,
        output halfDone);
endinterface
`default_nettype wire

// ===== verilog/dlss_lock_status.sv
`timescale 1ns/1ns
`default_nettype none
module dlss_lock_status #(
    parameter int HALF_MS_CYCLES = dlss_pkg::HALF_MS_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dlss_pkg::ADDR_W-1:0] paddr,
    input wire logic [dlss_pkg::DATA_W-1:0] pwdata,
    output logic [dlss_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // loop core inputs
    input wire logic signed [dlss_pkg::ERR_W-1:0] phaseErr,
    input wire logic refValid,
    input wire logic refSwitch,
    input wire logic [1:0] refSelect,
    input wire logic [dlss_pkg::FINE_W-1:0] tdcFine,
    input wire logic signed [dlss_pkg::SDM_W-1:0] sdmErr,
    // loop core outputs
    output logic fbDividerOn,
    output logic tdcEnable,
    output logic feedbackSourceSelect,
    output logic filterNormalSel,
    output logic [dlss_pkg::FINE_W-1:0] fineDigital,
    output logic signed [dlss_pkg::SDM_W+7:0] corrOut,
    output logic locked
);
    import dlss_pkg::*;

    function automatic logic [ERR_W-1:0] absVal(
        input logic signed [ERR_W-1:0] v);
        absVal = v[ERR_W-1] ? ERR_W'(-v) : ERR_W'(v);
    endfunction

    function automatic logic [FINE_W-1:0] revBits(
        input logic [FINE_W-1:0] v);
        for (int i = 0; i < FINE_W; i++) begin
            revBits[i] = v[FINE_W-1-i];
        end
    endfunction

    function automatic logic [2:0] stateCode(input dlss_state_e s);
        case (s)
            ST_NORMAL: stateCode = CODE_NORMAL;
            ST_HOLDOVER: stateCode = CODE_HOLDOVER;
            ST_WRFREQ: stateCode = CODE_WRFREQ;
            ST_ACQUIRE: stateCode = CODE_ACQUIRE;
            ST_HITLESS: stateCode = CODE_HITLESS;
            default: stateCode = CODE_FREERUN;
        endcase
    endfunction

    // registers
    logic [15:0] fbCorr_q;
    logic [31:0] lockCfg_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [EV_W-1:0] events_q;
    logic [EV_W-1:0] events_d;
    logic [EV_W-1:0] evMask_q;
    logic [DATA_W-1:0] prdata_q;

    // loop state
    dlss_state_e state_q;
    dlss_state_e state_d;
    logic locked_q;
    logic locked_d;
    logic [1:0] refSel_q;
    logic filtNorm_q;
    logic fbOn_q;
    logic [FINE_W-1:0] fine_q;
    logic signed [SDM_W-1:0] sdmDly_q;
    logic signed [SDM_W+7:0] corr_q;

    // field views
    wire loopEn = ctrl_q[CTRL_EN_BIT];
    wire bwSwitchEn = ctrl_q[CTRL_BWSW_BIT];
    wire writeFreqReq = ctrl_q[CTRL_WRFQ_BIT];
    wire divOff = fbCorr_q[FB_DIV_OFF_BIT];
    wire fineRev = fbCorr_q[FINE_REV_BIT];
    wire [1:0] pecDelay = fbCorr_q[PEC_DLY_LSB+:2];
    wire [PEC_MULT_W-1:0] pecMult = fbCorr_q[PEC_MULT_W-1:0];
    wire [15:0] lockTimer = lockCfg_q[LOCK_TIMER_LSB+:16];
    wire [15:0] lockThresh = lockCfg_q[15:0];

    // apb decode
    wire setupPh = psel && !penable;
    wire accessPh = psel && penable;
    wire wrEn = accessPh && pwrite;
    wire hitFb = (paddr == OFF_FB_CORR);
    wire hitLock = (paddr == OFF_LOCK_CFG);
    wire hitSts = (paddr == OFF_STATE_STS);
    wire hitEv = (paddr == OFF_EVENTS);
    wire hitMask = (paddr == OFF_EVENT_MASK);
    wire hitCtrl = (paddr == OFF_LOOP_CTRL);
    wire hitAny = hitFb || hitLock || hitSts || hitEv || hitMask || hitCtrl;

    wire [7:0] statusWord = {1'b0, stateCode(state_q),
        1'b0, refSel_q, locked_q};

    logic [DATA_W-1:0] readMux;
    always_comb begin
        readMux = '0;
        if (hitFb) begin
            readMux = DATA_W'(fbCorr_q);
        end else if (hitLock) begin
            readMux = lockCfg_q;
        end else if (hitSts) begin
            readMux = DATA_W'(statusWord);
        end else if (hitEv) begin
            readMux = DATA_W'(events_q);
        end else if (hitMask) begin
            readMux = DATA_W'(evMask_q);
        end else if (hitCtrl) begin
            readMux = DATA_W'(ctrl_q);
        end
    end

    // read data captured in setup, answered in the first access cycle
    assign pready = accessPh;
    assign pslverr = accessPh && !hitAny;
    assign prdata = prdata_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= '0;
        end else if (setupPh) begin
            prdata_q <= readMux;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fbCorr_q <= FB_CORR_RST;
            lockCfg_q <= {LOCK_TIMER_RST, LOCK_THRESH_RST};
            ctrl_q <= CTRL_RST;
            evMask_q <= '0;
        end else if (wrEn) begin
            if (hitFb) begin
                fbCorr_q <= pwdata[15:0] & FB_CORR_WMASK;
            end else if (hitLock) begin
                lockCfg_q <= pwdata;
            end else if (hitCtrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end else if (hitMask) begin
                evMask_q <= pwdata[EV_W-1:0] & EV_IMPL;
            end
        end
    end

    // lock qualification: threshold scaled by eight
    wire [ERR_W-1:0] absErr = absVal(phaseErr);
    wire [ERR_W-1:0] thrScaled = ERR_W'(lockThresh) << THRESH_SHIFT;
    wire errBelow = absErr < thrScaled;
    wire stateChg = (state_d != state_q);

    dlss_lock_if lk ();
    assign lk.lockTimer = lockTimer;
    assign lk.errBelow = errBelow;
    assign lk.restart = stateChg;
    wire halfDone = lk.halfDone;

    dlss_lock_timer #(
        .HALF_MS_CYCLES(HALF_MS_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .lk(lk.timer)
    );

    // loop state machine
    always_comb begin
        state_d = state_q;
        if (!loopEn) begin
            state_d = ST_FREERUN;
        end else begin
            case (state_q)
                ST_FREERUN: begin
                    if (writeFreqReq) begin
                        state_d = ST_WRFREQ;
                    end else if (refValid) begin
                        state_d = ST_ACQUIRE;
                    end
                end
                ST_ACQUIRE: begin
                    if (!refValid) begin
                        state_d = ST_HOLDOVER;
                    end else if (halfDone) begin
                        state_d = ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if (!refValid) begin
                        state_d = ST_HOLDOVER;
                    end else if (refSwitch) begin
                        state_d = ST_HITLESS;
                    end
                end
                ST_HITLESS: begin
                    if (!refValid) begin
                        state_d = ST_HOLDOVER;
                    end else if (halfDone) begin
                        state_d = ST_NORMAL;
                    end
                end
                ST_HOLDOVER: begin
                    if (refValid) begin
                        state_d = ST_ACQUIRE;
                    end
                end
                ST_WRFREQ: begin
                    if (!writeFreqReq) begin
                        state_d = ST_FREERUN;
                    end
                end
                default: state_d = ST_FREERUN;
            endcase
        end
    end

    // lock declared on the second half interval, dropped on large error
    wire stayNormal = (state_q == ST_NORMAL) && (state_d == ST_NORMAL);
    assign locked_d = stayNormal && errBelow &&
        (locked_q || halfDone);

    // sticky events; a new event beats a clear in the same cycle
    wire [EV_W-1:0] evClr = (wrEn && hitEv) ? pwdata[EV_W-1:0] : '0;
    wire [EV_W-1:0] evSet = EV_W'(
        (stateChg << EV_STCH_BIT) |
        ((locked_q && !locked_d) << EV_LOL_BIT) |
        ((state_d == ST_HOLDOVER && state_q != ST_HOLDOVER)
            << EV_HOLD_BIT));
    assign events_d = ((events_q & ~evClr) | evSet) & EV_IMPL;

    wire filtNorm_d = !bwSwitchEn ? 1'b1 :
        (state_d == ST_ACQUIRE) ? 1'b0 :
        (state_q == ST_ACQUIRE && state_d == ST_NORMAL) ? 1'b1 : filtNorm_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_FREERUN;
            locked_q <= 1'b0;
            events_q <= '0;
            refSel_q <= '0;
            filtNorm_q <= 1'b0;
        end else begin
            state_q <= state_d;
            locked_q <= locked_d;
            events_q <= events_d;
            refSel_q <= refSelect;
            filtNorm_q <= filtNorm_d;
        end
    end

    // feedback correction data path
    wire signed [SDM_W-1:0] sdmSel =
        (pecDelay == PEC_DLY_ONE) ? sdmDly_q : sdmErr;
    wire signed [SDM_W+7:0] corr_d =
        sdmSel * $signed({1'b0, pecMult});

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fbOn_q <= 1'b0;
            fine_q <= '0;
            sdmDly_q <= '0;
            corr_q <= '0;
        end else begin
            fbOn_q <= loopEn && !divOff;
            fine_q <= fineRev ? revBits(tdcFine) : tdcFine;
            sdmDly_q <= sdmErr;
            corr_q <= corr_d;
        end
    end

    assign fbDividerOn = fbOn_q;
    assign tdcEnable = ctrl_q[CTRL_TDC_BIT];
    assign feedbackSourceSelect = ctrl_q[CTRL_FBSEL_BIT];
    assign filterNormalSel = filtNorm_q;
    assign fineDigital = fine_q;
    assign corrOut = corr_q;
    assign locked = locked_q;
    assign irq = |(events_q & evMask_q);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    div_gate_a: assert property (!loopEn |=> !fbDividerOn)
        else $error("feedback divider on while loop disabled");

    fine_order_a: assert property (fineRev |=>
        fineDigital[0] == $past(tdcFine[FINE_W-1]) &&
        fineDigital[FINE_W-1] == $past(tdcFine[0]))
        else $error("fine timestamp order wrong when reversed");

    pec_delay_a: assert property (pecDelay == PEC_DLY_ONE |->
        sdmSel == $past(sdmErr))
        else $error("sigma-delta error not delayed one cycle");

    acq_normal_a: assert property (
        state_q == ST_ACQUIRE && state_d == ST_NORMAL |-> halfDone)
        else $error("acquire left for normal without half interval");

    bw_switch_a: assert property (bwSwitchEn &&
        state_q == ST_ACQUIRE ##1 state_q == ST_NORMAL |-> filterNormalSel)
        else $error("filter kept acquire settings after transition");

    lock_rise_a: assert property ($rose(locked_q) |->
        $past(state_q) == ST_NORMAL && $past(halfDone) &&
        $past(state_q, 2) == ST_NORMAL)
        else $error("lock declared without second half interval");

    lock_state_a: assert property (state_q != ST_NORMAL |-> !locked_q)
        else $error("lock shown outside normal state");

    state_code_a: assert property (state_q == ST_ACQUIRE |->
        statusWord[STS_STATE_LSB+:3] == CODE_ACQUIRE)
        else $error("acquire state reported with wrong code");

    state_flag_a: assert property (stateChg |=> events_q[EV_STCH_BIT])
        else $error("state change flag not set");

    lol_flag_a: assert property ($fell(locked_q) |-> events_q[EV_LOL_BIT])
        else $error("loss-of-lock flag not set on lock drop");

    hold_flag_a: assert property ($rose(state_q == ST_HOLDOVER) |->
        events_q[EV_HOLD_BIT] ##1
        (events_q[EV_HOLD_BIT] || $past(evClr[EV_HOLD_BIT])))
        else $error("holdover flag not set on entry");
endmodule // dlss_lock_status
`default_nettype wire

// ===== verilog/dlss_lock_timer.sv
`timescale 1ns/1ns
`default_nettype none
module dlss_lock_timer #(
    parameter int HALF_MS_CYCLES = dlss_pkg::HALF_MS_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // qualification port
    dlss_lock_if.timer lk
);
    import dlss_pkg::*;
    localparam int DIV_W = $clog2(HALF_MS_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_MS_CYCLES - 1);

    logic [DIV_W-1:0] divCnt_q;
    logic [15:0] halfCnt_q;
    logic halfDone_q;
    wire hold = !lk.errBelow || lk.restart;
    wire tick = (divCnt_q == DIV_LAST);
    // lockTimer is in ms, so half of it is lockTimer half-ms ticks
    wire reach = tick && (halfCnt_q + 16'h0001 >= lk.lockTimer);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_q <= '0;
            halfCnt_q <= '0;
            halfDone_q <= 1'b0;
        end else if (hold) begin
            divCnt_q <= '0;
            halfCnt_q <= '0;
            halfDone_q <= 1'b0;
        end else begin
            divCnt_q <= tick ? '0 : divCnt_q + 1'b1;
            halfCnt_q <= reach ? '0 : halfCnt_q + 16'(tick);
            halfDone_q <= reach;
        end
    end
    assign lk.halfDone = halfDone_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    tick_restart_a: assert property (!lk.errBelow |=> halfCnt_q == 16'h0000
        && divCnt_q == '0 && !lk.halfDone)
        else $error("half interval counter not restarted by large error");
endmodule // dlss_lock_timer
`default_nettype wire

// ===== verilog/dlss_pkg.sv
`default_nettype none
package dlss_pkg;
    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFF_FB_CORR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LOCK_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATE_STS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EVENTS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LOOP_CTRL = 8'h14;

    // feedback_correction_config fields
    localparam int FB_DIV_OFF_BIT = 15;
    localparam int FINE_REV_BIT = 9;
    localparam int PEC_DLY_LSB = 7;
    localparam int PEC_MULT_W = 7;
    localparam logic [15:0] FB_CORR_RST = 16'h0000;
    localparam logic [15:0] FB_CORR_WMASK = 16'h83ff;
    localparam logic [1:0] PEC_DLY_ONE = 2'h1;

    // lock_detect_config fields
    localparam int LOCK_TIMER_LSB = 16;
    localparam logic [15:0] LOCK_TIMER_RST = 16'h00ff;
    localparam logic [15:0] LOCK_THRESH_RST = 16'h0155;
    localparam int THRESH_SHIFT = 3;

    // loop_state_status fields
    localparam int STS_STATE_LSB = 4;
    localparam int STS_REF_LSB = 1;
    localparam int STS_LOCK_BIT = 0;

    // loop_event_flags fields
    localparam int EV_W = 8;
    localparam int EV_LOL_BIT = 0;
    localparam int EV_HOLD_BIT = 2;
    localparam int EV_STCH_BIT = 3;
    localparam logic [EV_W-1:0] EV_IMPL = 8'h0d;

    // loop control register
    localparam int CTRL_W = 5;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_TDC_BIT = 1;
    localparam int CTRL_BWSW_BIT = 2;
    localparam int CTRL_FBSEL_BIT = 3;
    localparam int CTRL_WRFQ_BIT = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int HALF_MS_CYCLES = (MS_NS / 2) / CLK_PERIOD_NS;

    // data paths
    localparam int FINE_W = 31;
    localparam int SDM_W = 16;
    localparam int ERR_W = 32;

    typedef enum logic [2:0] {
        ST_FREERUN, ST_NORMAL, ST_HOLDOVER, ST_WRFREQ, ST_ACQUIRE, ST_HITLESS
    } dlss_state_e;

    // encodings reported in the state field
    localparam logic [2:0] CODE_FREERUN = 3'h0;
    localparam logic [2:0] CODE_NORMAL = 3'h1;
    localparam logic [2:0] CODE_HOLDOVER = 3'h2;
    localparam logic [2:0] CODE_WRFREQ = 3'h3;
    localparam logic [2:0] CODE_ACQUIRE = 3'h4;
    localparam logic [2:0] CODE_HITLESS = 3'h5;
endpackage
`default_nettype wire
